// ### verilog/tpm_pkg.sv
package tpm_pkg;
  typedef enum logic [1:0] {
    TPM_FREE = 2'b00,
    TPM_ONE  = 2'b01,
    TPM_PWM  = 2'b11
  } tpm_mode_t;

  // ==========================================
  // Register indices
  localparam logic [3:0] REG_CTRL_B = 4'h0;
  localparam logic [3:0] REG_CTRL_A = 4'h1;
  localparam logic [3:0] REG_FLAGS  = 4'h2;
  localparam logic [3:0] REG_CAPA_H = 4'h3;
  localparam logic [3:0] REG_CAPA_L = 4'h4;
  localparam logic [3:0] REG_CMP1_H = 4'h5;
  localparam logic [3:0] REG_CMP1_L = 4'h6;
  localparam logic [3:0] REG_CNT_H  = 4'h7;
  localparam logic [3:0] REG_CNT_L  = 4'h8;
  localparam logic [3:0] REG_ALT_H  = 4'h9;
  localparam logic [3:0] REG_ALT_L  = 4'ha;
  localparam logic [3:0] REG_CAPB_H = 4'hb;
  localparam logic [3:0] REG_CAPB_L = 4'hc;
  localparam logic [3:0] REG_CMP2_H = 4'hd;
  localparam logic [3:0] REG_CMP2_L = 4'he;

  // ==========================================
  // Control A bit positions
  localparam int A_CAP_IE = 7;
  localparam int A_CMP_IE = 6;
  localparam int A_OVF_IE = 5;
  localparam int A_FORCE2 = 4;
  localparam int A_FORCE1 = 3;
  localparam int A_LVL2   = 2;
  localparam int A_EDGE1  = 1;
  localparam int A_LVL1   = 0;
  // Control B bit positions
  localparam int B_PIN1_E = 7;
  localparam int B_PIN2_E = 6;
  localparam int B_SINGLE = 5;
  localparam int B_PWM    = 4;
  localparam int B_SRC_HI = 3;
  localparam int B_SRC_LO = 2;
  localparam int B_EDGE2  = 1;
  localparam int B_EXEDGE = 0;
  // Flag bit positions
  localparam int F_CAPA = 7;
  localparam int F_CMP1 = 6;
  localparam int F_OVF  = 5;
  localparam int F_CAPB = 4;
  localparam int F_CMP2 = 3;

  // ==========================================
  // Values
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] CAP_TRIG   = 16'hfffd;
  localparam logic [15:0] CMP_RST    = 16'h8000;
  localparam logic [15:0] CNT_TOP    = 16'hffff;
  localparam logic [1:0]  SRC_DIV4   = 2'h0;
  localparam logic [1:0]  SRC_DIV2   = 2'h1;
  localparam logic [1:0]  SRC_DIV8   = 2'h2;
  localparam logic [2:0]  TERM_DIV2  = 3'h1;
  localparam logic [2:0]  TERM_DIV4  = 3'h3;
  localparam logic [2:0]  TERM_DIV8  = 3'h7;
endpackage : tpm_pkg

// ### verilog/tpm_timer.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module tpm_timer (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       trigger_capture_pin_a,
  input  wire logic       capture_pin_b,
  input  wire logic       ext_clk_pin,
  input  wire logic       cpu_irq_mask,
  input  wire logic       wait_mode,
  input  wire logic       halt_mode,
  input  wire logic       reset_wake,
  output logic            waveform_out_pin,
  output logic            waveform_pin_enable,
  output logic            waveform_out_pin_b,
  output logic            waveform_pin_b_enable,
  output logic            timer_irq,
  output logic            wait_exit
);
  // ==========================================
  // Control and mode
  logic [7:0]  ctrl_a_q;
  logic [7:0]  ctrl_b_q;
  logic [15:0] cmp1_q;
  logic [15:0] cmp2_q;
  logic [15:0] capa_q;
  logic [15:0] capb_q;
  logic [15:0] cnt_q;
  logic [7:0]  lat_q;
  logic [4:0]  flag_q;
  logic [4:0]  armed_q;
  logic        cmp1_on_q;
  logic        cmp2_on_q;
  logic        capa_on_q;
  logic        capb_on_q;
  logic        pin_a_q;
  logic        pin_b_q;
  logic        ext_q;
  logic        halt_q;
  logic        hold_a_q;
  logic        hold_b_q;
  logic [2:0]  pre_q;
  logic [7:0]  rdata_q;
  logic        irq_q;
  logic        wexit_q;
  tpm_pkg::tpm_mode_t mode;
  logic        run;
  logic        tick;
  logic        edge_a;
  logic        edge_b;
  logic        m1;
  logic        m2;
  logic        trig;
  logic        halt_exit;
  logic [2:0]  term;
  logic [4:0]  set;
  logic [4:0]  clr;
  logic        wr_a;
  logic        any_irq;

  always_comb begin
    if (ctrl_b_q[tpm_pkg::B_PWM])
      mode = tpm_pkg::TPM_PWM;
    else if (ctrl_b_q[tpm_pkg::B_SINGLE])
      mode = tpm_pkg::TPM_ONE;
    else
      mode = tpm_pkg::TPM_FREE;
  end

  // Halt stops the prescaler, counter and matches and defers captures to halt exit; wait does not
  assign run = ~halt_mode;
  assign halt_exit = halt_q & ~halt_mode & ~reset_wake;
  assign wr_a = reg_wr & (reg_addr == tpm_pkg::REG_CTRL_A);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_a_q <= tpm_pkg::CTRL_RST;
      ctrl_b_q <= tpm_pkg::CTRL_RST;
    end else begin
      if (wr_a)
        ctrl_a_q <= reg_wdata;
      if (reg_wr & (reg_addr == tpm_pkg::REG_CTRL_B))
        ctrl_b_q <= reg_wdata;
    end
  end

  // ==========================================
  // Tick generation
  always_comb begin
    case (ctrl_b_q[tpm_pkg::B_SRC_HI:tpm_pkg::B_SRC_LO])
      tpm_pkg::SRC_DIV4: term = tpm_pkg::TERM_DIV4;
      tpm_pkg::SRC_DIV2: term = tpm_pkg::TERM_DIV2;
      tpm_pkg::SRC_DIV8: term = tpm_pkg::TERM_DIV8;
      default:           term = tpm_pkg::TERM_DIV8;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pre_q  <= 3'h0;
      ext_q  <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      ext_q  <= ext_clk_pin;
      halt_q <= halt_mode;
      if (run)
        pre_q <= (pre_q >= term) ? 3'h0 : pre_q + 3'h1;
    end
  end

  always_comb begin
    if (ctrl_b_q[tpm_pkg::B_SRC_HI] & ctrl_b_q[tpm_pkg::B_SRC_LO])
      tick = run & (ctrl_b_q[tpm_pkg::B_EXEDGE] ? (ext_clk_pin & ~ext_q) : (~ext_clk_pin & ext_q));
    else
      tick = run & (pre_q >= term);
  end

  // ==========================================
  // Edges and matches
  logic pa_q;
  logic pb_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pa_q <= 1'b0;
      pb_q <= 1'b0;
    end else begin
      pa_q <= trigger_capture_pin_a;
      pb_q <= capture_pin_b;
    end
  end

  assign edge_a = ctrl_a_q[tpm_pkg::A_EDGE1] ? (trigger_capture_pin_a & ~pa_q) : (~trigger_capture_pin_a & pa_q);
  assign edge_b = ctrl_b_q[tpm_pkg::B_EDGE2] ? (capture_pin_b & ~pb_q) : (~capture_pin_b & pb_q);
  assign trig = run & edge_a & (mode == tpm_pkg::TPM_ONE);
  assign m1 = tick & cmp1_on_q & (cnt_q == cmp1_q);
  assign m2 = tick & cmp2_on_q & (cnt_q == cmp2_q);

  // ==========================================
  // Counter
  always_ff @(posedge sys_clk) begin
    if (sys_rst | reset_wake)
      cnt_q <= tpm_pkg::CNT_RELOAD;
    else if (trig)
      cnt_q <= tpm_pkg::CNT_RELOAD;
    else if (tick & (mode == tpm_pkg::TPM_PWM) & m2)
      cnt_q <= tpm_pkg::CNT_RELOAD;
    else if (tick)
      cnt_q <= cnt_q + 16'h0001;
  end

  // ==========================================
  // Compare registers
  // High byte write parks the compare so a half-written value never matches
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmp1_q    <= tpm_pkg::CMP_RST;
      cmp2_q    <= tpm_pkg::CMP_RST;
      cmp1_on_q <= 1'b1;
      cmp2_on_q <= 1'b1;
    end else if (reg_wr) begin
      case (reg_addr)
        tpm_pkg::REG_CMP1_H: begin
          cmp1_q[15:8] <= reg_wdata;
          cmp1_on_q    <= 1'b0;
        end
        tpm_pkg::REG_CMP1_L: begin
          cmp1_q[7:0] <= reg_wdata;
          cmp1_on_q   <= 1'b1;
        end
        tpm_pkg::REG_CMP2_H: begin
          cmp2_q[15:8] <= reg_wdata;
          cmp2_on_q    <= 1'b0;
        end
        tpm_pkg::REG_CMP2_L: begin
          cmp2_q[7:0] <= reg_wdata;
          cmp2_on_q   <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // Captures
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_a_q <= 1'b0;
      hold_b_q <= 1'b0;
    end else if (reset_wake | halt_exit) begin
      hold_a_q <= 1'b0;
      hold_b_q <= 1'b0;
    end else if (halt_mode) begin
      if (edge_a & (mode == tpm_pkg::TPM_FREE))
        hold_a_q <= 1'b1;
      if (edge_b)
        hold_b_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      capa_q    <= 16'h0000;
      capb_q    <= 16'h0000;
      capa_on_q <= 1'b1;
      capb_on_q <= 1'b1;
    end else begin
      if (trig)
        capa_q <= tpm_pkg::CAP_TRIG;
      else if (halt_exit & hold_a_q)
        capa_q <= cnt_q;
      else if (run & edge_a & capa_on_q & (mode == tpm_pkg::TPM_FREE))
        capa_q <= cnt_q;
      if ((halt_exit & hold_b_q) | (run & edge_b & capb_on_q))
        capb_q <= cnt_q;
      if (reg_rd & (reg_addr == tpm_pkg::REG_CAPA_H))
        capa_on_q <= 1'b0;
      else if (reg_rd & (reg_addr == tpm_pkg::REG_CAPA_L))
        capa_on_q <= 1'b1;
      if (reg_rd & (reg_addr == tpm_pkg::REG_CAPB_H))
        capb_on_q <= 1'b0;
      else if (reg_rd & (reg_addr == tpm_pkg::REG_CAPB_L))
        capb_on_q <= 1'b1;
    end
  end

  // ==========================================
  // Flags
  always_comb begin
    set = 5'h00;
    set[4] = (run & edge_a & capa_on_q & (mode == tpm_pkg::TPM_FREE)) | trig
           | ((mode == tpm_pkg::TPM_PWM) & m2) | (halt_exit & hold_a_q);
    set[3] = (mode == tpm_pkg::TPM_FREE) & m1;
    set[2] = tick & (cnt_q == tpm_pkg::CNT_TOP) & ~((mode == tpm_pkg::TPM_PWM) & m2);
    set[1] = (run & edge_b & capb_on_q) | (halt_exit & hold_b_q);
    set[0] = (mode != tpm_pkg::TPM_PWM) & m2;
    clr = 5'h00;
    clr[4] = (reg_rd | reg_wr) & (reg_addr == tpm_pkg::REG_CAPA_L);
    clr[3] = (reg_rd | reg_wr) & (reg_addr == tpm_pkg::REG_CMP1_L);
    clr[2] = (reg_rd | reg_wr) & (reg_addr == tpm_pkg::REG_CNT_L);
    clr[1] = (reg_rd | reg_wr) & (reg_addr == tpm_pkg::REG_CAPB_L);
    clr[0] = (reg_rd | reg_wr) & (reg_addr == tpm_pkg::REG_CMP2_L);
  end

  // Set beats clear in the same cycle, so no event is lost
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flag_q  <= 5'h00;
      armed_q <= 5'h00;
    end else begin
      flag_q <= set | (flag_q & ~(clr & armed_q));
      if (reg_rd & (reg_addr == tpm_pkg::REG_FLAGS))
        armed_q <= flag_q;
      else
        armed_q <= armed_q & ~clr;
    end
  end

  // ==========================================
  // Waveform pins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
    end else begin
      case (mode)
        tpm_pkg::TPM_ONE: begin
          if (trig)
            pin_a_q <= ctrl_a_q[tpm_pkg::A_LVL2];
          else if (m1)
            pin_a_q <= ctrl_a_q[tpm_pkg::A_LVL1];
        end
        tpm_pkg::TPM_PWM: begin
          if (m2)
            pin_a_q <= ctrl_a_q[tpm_pkg::A_LVL2];
          else if (m1)
            pin_a_q <= ctrl_a_q[tpm_pkg::A_LVL1];
        end
        default: begin
          if (wr_a & reg_wdata[tpm_pkg::A_FORCE1])
            pin_a_q <= reg_wdata[tpm_pkg::A_LVL1];
          else if (m1)
            pin_a_q <= ctrl_a_q[tpm_pkg::A_LVL1];
          if (wr_a & reg_wdata[tpm_pkg::A_FORCE2])
            pin_b_q <= reg_wdata[tpm_pkg::A_LVL2];
          else if (m2)
            pin_b_q <= ctrl_a_q[tpm_pkg::A_LVL2];
        end
      endcase
    end
  end

  // Second pin is left alone outside free mode, its level serves the pulse
  assign waveform_out_pin      = pin_a_q;
  assign waveform_pin_enable   = ctrl_b_q[tpm_pkg::B_PIN1_E];
  assign waveform_out_pin_b    = pin_b_q;
  assign waveform_pin_b_enable = ctrl_b_q[tpm_pkg::B_PIN2_E];

  // ==========================================
  // Interrupt request
  assign any_irq = ~cpu_irq_mask & (
                   (ctrl_a_q[tpm_pkg::A_CAP_IE] & (flag_q[4] | flag_q[1]))
                 | (ctrl_a_q[tpm_pkg::A_CMP_IE] & (flag_q[3] | flag_q[0]))
                 | (ctrl_a_q[tpm_pkg::A_OVF_IE] & flag_q[2]));

  // Halt never ends here: no flag can set while halted
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_q   <= 1'b0;
      wexit_q <= 1'b0;
    end else begin
      irq_q   <= any_irq;
      wexit_q <= any_irq & wait_mode;
    end
  end

  assign timer_irq = irq_q;
  assign wait_exit = wexit_q;

  // ==========================================
  // Register read
  // High byte read latches low byte so a 16-bit read is coherent
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      lat_q <= 8'h00;
    else if (reg_rd & ((reg_addr == tpm_pkg::REG_CNT_H) | (reg_addr == tpm_pkg::REG_ALT_H)))
      lat_q <= cnt_q[7:0];
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      rdata_q <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        tpm_pkg::REG_CTRL_B: rdata_q <= ctrl_b_q;
        tpm_pkg::REG_CTRL_A: rdata_q <= ctrl_a_q;
        tpm_pkg::REG_FLAGS:  rdata_q <= {flag_q, 3'h0};
        tpm_pkg::REG_CAPA_H: rdata_q <= capa_q[15:8];
        tpm_pkg::REG_CAPA_L: rdata_q <= capa_q[7:0];
        tpm_pkg::REG_CMP1_H: rdata_q <= cmp1_q[15:8];
        tpm_pkg::REG_CMP1_L: rdata_q <= cmp1_q[7:0];
        tpm_pkg::REG_CNT_H:  rdata_q <= cnt_q[15:8];
        tpm_pkg::REG_CNT_L:  rdata_q <= lat_q;
        tpm_pkg::REG_ALT_H:  rdata_q <= cnt_q[15:8];
        tpm_pkg::REG_ALT_L:  rdata_q <= lat_q;
        tpm_pkg::REG_CAPB_H: rdata_q <= capb_q[15:8];
        tpm_pkg::REG_CAPB_L: rdata_q <= capb_q[7:0];
        tpm_pkg::REG_CMP2_H: rdata_q <= cmp2_q[15:8];
        tpm_pkg::REG_CMP2_L: rdata_q <= cmp2_q[7:0];
        default:             rdata_q <= 8'h00;
      endcase
    end else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;
endmodule : tpm_timer

// ### testbench/tpm_timer_chk_asserts.sv
`timescale 1ns/1ps
module tpm_timer_chk (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       cpu_irq_mask,
  input wire logic       wait_mode,
  input wire logic       halt_mode,
  input wire logic       waveform_out_pin,
  input wire logic       waveform_pin_enable,
  input wire logic       timer_irq,
  input wire logic       wait_exit
);
  // ==========================================
  // Port relations
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_rst_quiet;
    disable iff (1'b0) $fell(sys_rst) |-> !waveform_out_pin && !timer_irq && reg_rdata == 8'h00;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
  property p_mask;
    timer_irq |-> !$past(cpu_irq_mask);
  endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  property p_wait_exit;
    wait_exit |-> timer_irq && $past(wait_mode);
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("wait exit without cause");
  property p_rdata_idle;
    reg_rdata != 8'h00 |-> $past(reg_rd);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
  property p_unmapped;
    $past(reg_rd) && $past(reg_addr) == 4'hf |-> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Two cycles of settling, since a tick just before halt may land
  property p_halt_pin;
    halt_mode && $past(halt_mode) && $past(halt_mode, 2) |-> $stable(waveform_out_pin);
  endproperty
  a_halt_pin: assert property (p_halt_pin) else $error("pin moved in halt");
  property p_halt_irq;
    halt_mode && $past(halt_mode) && $past(halt_mode, 2) && !$past(reg_wr) && !$past(reg_wr, 2)
      && ($past(cpu_irq_mask) == $past(cpu_irq_mask, 2)) |-> !$rose(timer_irq);
  endproperty
  a_halt_irq: assert property (p_halt_irq) else $error("event raised in halt");
  property p_pin_en;
    !$past(reg_wr) |-> $stable(waveform_pin_enable);
  endproperty
  a_pin_en: assert property (p_pin_en) else $error("pin enable moved without write");
endmodule : tpm_timer_chk

// ### testbench/tpm_far_side.sv
`timescale 1ns/1ps
module tpm_far_side (
  input  wire logic sys_clk,
  input  wire logic waveform_out_pin,
  input  wire logic waveform_pin_enable,
  output logic      trigger_capture_pin_a,
  output logic      capture_pin_b,
  output logic      ext_clk_pin,
  output int        high_len,
  output int        period_len
);
  int   hi_run;
  int   per_run;
  logic pin_q;
  initial begin
    trigger_capture_pin_a = 1'b0;
    capture_pin_b = 1'b0;
    ext_clk_pin = 1'b0;
    high_len = 0;
    period_len = 0;
    hi_run = 0;
    per_run = 0;
    pin_q = 1'b0;
  end
  // ==========================================
  // Stimulus; held several clocks so the synchroniser sees it
  task automatic edge_a();
    @(posedge sys_clk) trigger_capture_pin_a <= 1'b1;
    repeat (3) @(posedge sys_clk);
    trigger_capture_pin_a <= 1'b0;
  endtask : edge_a
  task automatic pulse_b();
    @(posedge sys_clk) capture_pin_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    capture_pin_b <= 1'b0;
  endtask : pulse_b
  // Clock stands still between bursts
  task automatic ext_ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk) ext_clk_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ext_clk_pin <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask : ext_ticks
  // ==========================================
  // Pin measurement in clock cycles
  always @(posedge sys_clk) begin
    pin_q <= waveform_out_pin;
    if (waveform_pin_enable && waveform_out_pin) begin
      hi_run <= hi_run + 1;
    end else if (hi_run != 0) begin
      high_len <= hi_run;
      hi_run <= 0;
    end
    if (waveform_out_pin && !pin_q) begin
      period_len <= per_run;
      per_run <= 1;
    end else begin
      per_run <= per_run + 1;
    end
  end
endmodule : tpm_far_side

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       pin_a, pin_b, ext_clk, wave, wave_en, wave_b, wave_b_en;
  logic       cpu_irq_mask = 1'b0;
  logic       wait_mode = 1'b0;
  logic       halt_mode = 1'b0;
  logic       reset_wake = 1'b0;
  logic       timer_irq, wait_exit;
  int         high_len, period_len, fails, compares, lows;
  logic [15:0] v, v1;
  always #2 sys_clk = ~sys_clk;
  tpm_timer tpm_timer_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_capture_pin_a(pin_a),
    .capture_pin_b(pin_b), .ext_clk_pin(ext_clk), .cpu_irq_mask(cpu_irq_mask), .wait_mode(wait_mode),
    .halt_mode(halt_mode), .reset_wake(reset_wake), .waveform_out_pin(wave), .waveform_pin_enable(wave_en),
    .waveform_out_pin_b(wave_b), .waveform_pin_b_enable(wave_b_en), .timer_irq(timer_irq),
    .wait_exit(wait_exit));
  tpm_far_side far_i (.sys_clk(sys_clk), .waveform_out_pin(wave), .waveform_pin_enable(wave_en),
    .trigger_capture_pin_a(pin_a), .capture_pin_b(pin_b), .ext_clk_pin(ext_clk),
    .high_len(high_len), .period_len(period_len));
  // ==========================================
  // Bus and checking
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // High byte first: it latches the low byte of the counter
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd(a, d[15:8]);
    rd(a + 4'h1, d[7:0]);
  endtask : rd16
  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic do_reset();
    @(posedge sys_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask : do_reset
  // ==========================================
  // Scenarios
  task automatic s_reset_vals();
    rd16(tpm_pkg::REG_CMP1_H, v); chk(v, tpm_pkg::CMP_RST);
    rd16(tpm_pkg::REG_CMP2_H, v); chk(v, tpm_pkg::CMP_RST);
    rd(tpm_pkg::REG_CTRL_A, v[7:0]); chk(v[7:0], 8'h00);
    rd(tpm_pkg::REG_FLAGS, v[7:0]); chk(v[7:0], 8'h00);
    rd(4'hf, v[7:0]); chk(v[7:0], 8'h00);
    chk(wave, 1'b0);
  endtask : s_reset_vals
  task automatic s_ext_count();
    @(posedge sys_clk) reset_wake <= 1'b1;
    wr(tpm_pkg::REG_CTRL_B, 8'h0d);
    @(posedge sys_clk) reset_wake <= 1'b0;
    far_i.ext_ticks(5);
    rd16(tpm_pkg::REG_CNT_H, v); chk(v, 16'h0001);
    rd(tpm_pkg::REG_FLAGS, v[7:0]); chk(v[7:0] & 8'h20, 8'h20);
    wr(tpm_pkg::REG_CTRL_B, 8'h00);
  endtask : s_ext_count
  task automatic s_halt();
    @(posedge sys_clk) halt_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd16(tpm_pkg::REG_CNT_H, v1);
    far_i.pulse_b();
    repeat (40) @(posedge sys_clk);
    rd16(tpm_pkg::REG_CNT_H, v); chk(v, v1);
    rd(tpm_pkg::REG_FLAGS, v[7:0]); chk(v[7:0] & 8'h10, 8'h00);
    @(posedge sys_clk) halt_mode <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(tpm_pkg::REG_FLAGS, v[7:0]); chk(v[7:0] & 8'h10, 8'h10);
    rd16(tpm_pkg::REG_CAPB_H, v); chk(v, v1);
    @(posedge sys_clk) {halt_mode, reset_wake} <= 2'b11;
    repeat (3) @(posedge sys_clk);
    rd16(tpm_pkg::REG_CNT_H, v); chk(v, tpm_pkg::CNT_RELOAD);
    @(posedge sys_clk) {halt_mode, reset_wake} <= 2'b00;
  endtask : s_halt
  // Single-pulse bit also set: PWM must win
  task automatic s_pwm();
    wr(tpm_pkg::REG_CMP1_H, 8'h00);
    wr(tpm_pkg::REG_CMP1_L, 8'h04);
    wr(tpm_pkg::REG_CMP2_H, 8'h00);
    wr(tpm_pkg::REG_CMP2_L, 8'h0a);
    wr(tpm_pkg::REG_CTRL_A, 8'h81);
    wr(tpm_pkg::REG_CTRL_B, 8'hb4);
    repeat (120) @(posedge sys_clk);
    chk(16'(high_len), 16'd12);
    chk(16'(period_len), 16'd30);
    rd(tpm_pkg::REG_FLAGS, v[7:0]); chk(v[7:0] & 8'hc8, 8'h80);
    chk(timer_irq, 1'b1);
    @(posedge sys_clk) wait_mode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk(wait_exit, 1'b1);
    @(posedge sys_clk) {wait_mode, cpu_irq_mask} <= 2'b01;
    repeat (2) @(posedge sys_clk);
    #1 chk(timer_irq, 1'b0);
    @(posedge sys_clk) cpu_irq_mask <= 1'b0;
    wr(tpm_pkg::REG_CTRL_A, 8'h85);
    repeat (40) @(posedge sys_clk);
    lows = 0;
    repeat (60) @(posedge sys_clk) lows += int'(!wave);
    chk(16'(lows), 16'd0);
    wr(tpm_pkg::REG_CTRL_A, 8'h81);
    repeat (40) @(posedge sys_clk);
    wr(tpm_pkg::REG_CMP2_H, 8'h00);
    repeat (40) @(posedge sys_clk);
    lows = 0;
    repeat (60) @(posedge sys_clk) lows += int'(!wave);
    chk(16'(lows), 16'd0);
    chk(wave, 1'b1);
    // Pin A edge must not capture in PWM; pin B still does
    rd16(tpm_pkg::REG_CAPA_H, v1);
    far_i.edge_a();
    far_i.pulse_b();
    repeat (4) @(posedge sys_clk);
    rd16(tpm_pkg::REG_CAPA_H, v); chk(v, v1);
    rd(tpm_pkg::REG_FLAGS, v[7:0]); chk(v[7:0] & 8'h10, 8'h10);
  endtask : s_pwm
  task automatic s_single();
    wr(tpm_pkg::REG_CMP1_H, 8'h00);
    wr(tpm_pkg::REG_CMP1_L, 8'h08);
    wr(tpm_pkg::REG_CMP2_H, 8'h00);
    wr(tpm_pkg::REG_CMP2_L, 8'h04);
    wr(tpm_pkg::REG_CTRL_A, 8'h06);
    wr(tpm_pkg::REG_CTRL_B, 8'he0);
    repeat (10) @(posedge sys_clk);
    far_i.edge_a();
    repeat (2) @(posedge sys_clk);
    chk(wave, 1'b1);
    rd(tpm_pkg::REG_FLAGS, v[7:0]); chk(v[7:0] & 8'hc0, 8'h80);
    rd16(tpm_pkg::REG_CAPA_H, v); chk(v, tpm_pkg::CAP_TRIG);
    repeat (80) @(posedge sys_clk);
    chk(16'(high_len), 16'd52);
    chk(wave, 1'b0);
    rd(tpm_pkg::REG_FLAGS, v[7:0]); chk(v[7:0] & 8'hc0, 8'h00);
    chk(v[7:0] & 8'h08, 8'h08);
    // Level two is high, so a driven second pin would show it
    chk(wave_b, 1'b0);
    chk(wave_b_en, 1'b1);
    far_i.pulse_b();
    repeat (4) @(posedge sys_clk);
    rd(tpm_pkg::REG_FLAGS, v[7:0]); chk(v[7:0] & 8'h90, 8'h10);
  endtask : s_single
  // ==========================================
  // Main sequence and watchdog
  initial begin
    fails = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    s_reset_vals();
    s_ext_count();
    s_halt();
    s_pwm();
    do_reset();
    s_single();
    results();
  end
  initial begin
    #200000;
    fails++;
    results();
  end
endmodule : testbench
bind tpm_timer tpm_timer_chk tpm_timer_chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_irq_mask(cpu_irq_mask),
  .wait_mode(wait_mode), .halt_mode(halt_mode), .waveform_out_pin(waveform_out_pin),
  .waveform_pin_enable(waveform_pin_enable), .timer_irq(timer_irq), .wait_exit(wait_exit));
